// ==== common/pdcp_pkg.sv ====
// Purpose: Constants for the PLL dynamic configuration port
// Assumes: Eight-bit register bank, five-bit address
// Notes:   Mux select field layout is a local convention
package pdcp_pkg;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 8;
  localparam int          NUM_REGS      = 32;
  // Vector bit positions, host to PLL
  localparam int          HV_CLK        = 16;
  localparam int          HV_RST        = 15;
  localparam int          HV_STB        = 14;
  localparam int          HV_WE         = 13;
  localparam int          HV_ADDR_HI    = 12;
  localparam int          HV_ADDR_LO    = 8;
  localparam int          HV_DATA_HI    = 7;
  localparam int          HV_DATA_LO    = 0;
  localparam int          HV_W          = 17;
  // Vector bit positions, PLL to host
  localparam int          PV_DATA_HI    = 8;
  localparam int          PV_DATA_LO    = 1;
  localparam int          PV_ACK        = 0;
  localparam int          PV_W          = 9;
  // Second PLL offset in the bridge address space
  localparam logic [7:0]  SECOND_PLL_OFS = 8'h20;
  // Section mux select registers, one per section A..D
  localparam logic [4:0]  SEL_REG_BASE  = 5'h1C;
  localparam int          NUM_SECT      = 4;
  localparam logic [7:0]  REG_RST_VAL   = 8'h00;
  // Select fields: mux0 [1:0], mux1 [3:2], mux2 [5:4], phase [6], trim [7]
  localparam int          MUX0_LO       = 0;
  localparam int          MUX1_LO       = 2;
  localparam int          MUX2_LO       = 4;
  localparam int          PHASE_BIT     = 6;
  localparam int          TRIM_BIT      = 7;
  typedef enum logic [0:0] {
    PDCP_IDLE = 1'b0,
    PDCP_ACK  = 1'b1
  } pdcp_state_t;
endpackage : pdcp_pkg

// ==== logic/pdcp_top.sv ====
// Purpose: PLL dynamic configuration port with register bank and
//          output section select decoding
// Assumes: All inputs synchronous to CORE_CLK
// Notes:   Bus reset clears only the bus handshake, not the bank
//          Host vector bit 16 is left unused; CORE_CLK clocks the bus
//
// Behaviour
// RL1 - Configuration values are writable at run time over the bus
// RL2 - Bus runs on its dedicated clock, vector bit 16; here CORE_CLK clocks the bus and bit 16 is unused
// RL3 - Bus reset clears bus interface only, registers keep values
// RL4 - Master marks access with strobe, bit 14, writes with bit 13
// RL5 - Master presents five-bit address on bits 12 to 8
// RL6 - Master supplies eight-bit write data on bits 7 to 0
// RL7 - Device returns eight-bit read data on bits 8 to 1
// RL8 - Device pulses acknowledge on bit 0 per access
// RL9 - Four output sections A to D feed the four output clocks
// RL10 - Sections B to D have three selection muxes and section A two, set by configuration
// RL11 - Sections C and D have phase adjust but no edge trim
// RL12 - Section A has no mux in position 1
// RL13 - A second PLL sits 0x20 higher in the bridge space
// RL14 - Strobe high writes if write enable else reads, one ack pulse
`timescale 1ns/100ps
module pdcp_top (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESET,
  input  wire logic [pdcp_pkg::HV_W-1:0]   HOST_VEC,
  output logic      [pdcp_pkg::PV_W-1:0]   PLL_VEC,
  output logic      [7:0]                  SECT_MUX0,
  output logic      [7:0]                  SECT_MUX1,
  output logic      [7:0]                  SECT_MUX2,
  output logic      [3:0]                  SECT_PHASE_EN,
  output logic      [3:0]                  SECT_TRIM_EN
);
  // Bus clock arrives in vector bit 16; the core clock carries the bus
  logic                                bus_rst;
  logic                                stb;
  logic                                we;
  logic [pdcp_pkg::ADDR_W-1:0]         addr;
  logic [pdcp_pkg::DATA_W-1:0]         wdata;
  logic                                take;
  logic                                wr_take;
  logic                                rd_take;

  // Handshake state
  pdcp_pkg::pdcp_state_t               state_r;
  pdcp_pkg::pdcp_state_t               state_nxt;
  logic                                ack_r;
  logic                                ack_nxt;
  logic [pdcp_pkg::DATA_W-1:0]         rdata_r;
  logic [pdcp_pkg::DATA_W-1:0]         rdata_nxt;

  // Register bank
  logic [pdcp_pkg::DATA_W-1:0]         bank_r   [pdcp_pkg::NUM_REGS];
  logic [pdcp_pkg::DATA_W-1:0]         bank_nxt [pdcp_pkg::NUM_REGS];

  // Section select fields and registers
  logic [1:0]                          mux0_sect  [pdcp_pkg::NUM_SECT];
  logic [1:0]                          mux1_sect  [pdcp_pkg::NUM_SECT];
  logic [1:0]                          mux2_sect  [pdcp_pkg::NUM_SECT];
  logic                                phase_sect [pdcp_pkg::NUM_SECT];
  logic                                trim_sect  [pdcp_pkg::NUM_SECT];
  logic [7:0]                          mux0_r;
  logic [7:0]                          mux1_r;
  logic [7:0]                          mux2_r;
  logic [3:0]                          phase_r;
  logic [3:0]                          trim_r;
  logic [7:0]                          mux0_nxt;
  logic [7:0]                          mux1_nxt;
  logic [7:0]                          mux2_nxt;
  logic [3:0]                          phase_nxt;
  logic [3:0]                          trim_nxt;

  // Field split of the host vector
  assign bus_rst = HOST_VEC[pdcp_pkg::HV_RST];                      // [RL3]
  assign stb     = HOST_VEC[pdcp_pkg::HV_STB];                      // [RL4]
  assign we      = HOST_VEC[pdcp_pkg::HV_WE];                       // [RL4]
  // Port offset only; the bridge adds 0x20 for a second PLL
  assign addr    = HOST_VEC[pdcp_pkg::HV_ADDR_HI:                   // [RL5]
                            pdcp_pkg::HV_ADDR_LO];                  // [RL13]
  assign wdata   = HOST_VEC[pdcp_pkg::HV_DATA_HI:
                            pdcp_pkg::HV_DATA_LO];                  // [RL6]

  // Access taken in idle only, never under bus reset
  assign take    = stb && !bus_rst &&
                   (state_r == pdcp_pkg::PDCP_IDLE);                // [RL14]
  assign wr_take = take && we;                                      // [RL1]
  assign rd_take = take && !we;                                     // [RL7]

  // Handshake: ack the cycle after the take, then idle again
  always_comb begin
    state_nxt = state_r;
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      pdcp_pkg::PDCP_IDLE: begin
        if (take) begin                                             // [RL14]
          ack_nxt   = 1'b1;                                         // [RL8]
          state_nxt = pdcp_pkg::PDCP_ACK;
        end
      end
      pdcp_pkg::PDCP_ACK: begin
        state_nxt = pdcp_pkg::PDCP_IDLE;                            // [RL14]
      end
      default: begin
        state_nxt = pdcp_pkg::PDCP_IDLE;
      end
    endcase
    if (rd_take) begin
      rdata_nxt = bank_r[addr];                                     // [RL7]
    end
    if (bus_rst) begin                                              // [RL3]
      state_nxt = pdcp_pkg::PDCP_IDLE;
      ack_nxt   = 1'b0;
      rdata_nxt = '0;
    end
  end

  // Bank next value; only a taken write changes an entry
  always_comb begin
    for (int i = 0; i < pdcp_pkg::NUM_REGS; i++) begin
      bank_nxt[i] = bank_r[i];
    end
    if (wr_take) begin
      bank_nxt[addr] = wdata;                                       // [RL1]
    end
  end

  // Bus state; reset of the whole block or bus reset only
  always_ff @(posedge CORE_CLK) begin                               // [RL2]
    if (RESET) begin
      state_r <= pdcp_pkg::PDCP_IDLE;
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Register bank, untouched by bus reset
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      for (int i = 0; i < pdcp_pkg::NUM_REGS; i++) begin
        bank_r[i] <= pdcp_pkg::REG_RST_VAL;
      end
    end else begin
      for (int i = 0; i < pdcp_pkg::NUM_REGS; i++) begin
        bank_r[i] <= bank_nxt[i];                                   // [RL3]
      end
    end
  end

  // Two-bit select field of a section register
  function automatic logic [1:0] sel_field(
    input logic [pdcp_pkg::DATA_W-1:0] r,
    input int                          lo
  );
    return r[lo +: 2];
  endfunction : sel_field

  // Per-section decode, A..D drive the four output clocks
  for (genvar s = 0; s < pdcp_pkg::NUM_SECT; s++) begin : g_sect  // [RL9]
    logic [pdcp_pkg::DATA_W-1:0] sr;
    assign sr            = bank_r[pdcp_pkg::SEL_REG_BASE + 5'(s)];
    assign mux0_sect[s]  = sel_field(sr, pdcp_pkg::MUX0_LO);        // [RL10]
    assign mux2_sect[s]  = sel_field(sr, pdcp_pkg::MUX2_LO);        // [RL10]
    assign phase_sect[s] = sr[pdcp_pkg::PHASE_BIT];                 // [RL11]
    // Section A has no mux 1
    if (s == 0) begin : g_no_mux1
      assign mux1_sect[s] = 2'h0;                                   // [RL12]
    end else begin : g_mux1
      assign mux1_sect[s] = sel_field(sr, pdcp_pkg::MUX1_LO);       // [RL12]
    end
    // Only A and B have edge trim
    if (s < 2) begin : g_trim
      assign trim_sect[s] = sr[pdcp_pkg::TRIM_BIT];                 // [RL11]
    end else begin : g_no_trim
      assign trim_sect[s] = 1'h0;                                   // [RL11]
    end
  end

  // Pack the section fields, two bits per section for the muxes
  always_comb begin
    mux0_nxt  = '0;
    mux1_nxt  = '0;
    mux2_nxt  = '0;
    phase_nxt = '0;
    trim_nxt  = '0;
    for (int s = 0; s < pdcp_pkg::NUM_SECT; s++) begin
      mux0_nxt[2*s +: 2] = mux0_sect[s];                            // [RL10]
      mux1_nxt[2*s +: 2] = mux1_sect[s];                            // [RL12]
      mux2_nxt[2*s +: 2] = mux2_sect[s];                            // [RL10]
      phase_nxt[s]       = phase_sect[s];                           // [RL11]
      trim_nxt[s]        = trim_sect[s];                            // [RL11]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mux0_r  <= '0;
      mux1_r  <= '0;
      mux2_r  <= '0;
      phase_r <= '0;
      trim_r  <= '0;
    end else begin
      mux0_r  <= mux0_nxt;
      mux1_r  <= mux1_nxt;
      mux2_r  <= mux2_nxt;
      phase_r <= phase_nxt;
      trim_r  <= trim_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign PLL_VEC       = {rdata_r, ack_r};                          // [RL7] [RL8]
  assign SECT_MUX0     = mux0_r;
  assign SECT_MUX1     = mux1_r;
  assign SECT_MUX2     = mux2_r;
  assign SECT_PHASE_EN = phase_r;
  assign SECT_TRIM_EN  = trim_r;
endmodule : pdcp_top

// ==== bench/pdcp_properties.sv ====
// Purpose: Port checks for the configuration port
// Assumes: One clock, synchronous reset
// Notes:   Bound into pdcp_top
`timescale 1ns/100ps
module pdcp_properties (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic [16:0] HOST_VEC,
  input wire logic [8:0]  PLL_VEC,
  input wire logic [7:0]  SECT_MUX0,
  input wire logic [7:0]  SECT_MUX1,
  input wire logic [7:0]  SECT_MUX2,
  input wire logic [3:0]  SECT_PHASE_EN,
  input wire logic [3:0]  SECT_TRIM_EN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic take;
  assign take = HOST_VEC[14] && !HOST_VEC[15] && !PLL_VEC[0];
  a_ack_after_take: assert property (take |=> PLL_VEC[0])
    else $error("ack missing after strobe");
  a_ack_one_cycle: assert property (PLL_VEC[0] |=> !PLL_VEC[0])
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (PLL_VEC[0] |-> $past(take))
    else $error("ack without request");
  a_bus_rst_clear: assert property (HOST_VEC[15] |=> !PLL_VEC)
    else $error("bus reset left ack or data");
  a_rdata_holds: assert property (!$past(HOST_VEC[15]) &&
    !(PLL_VEC[0] && !$past(HOST_VEC[13])) |-> $stable(PLL_VEC[8:1]))
    else $error("read data moved without read");
  a_mux1_a_none: assert property (SECT_MUX1[1:0] == 2'h0)
    else $error("section A mux 1 set");
  a_trim_cd_none: assert property (SECT_TRIM_EN[3:2] == 2'h0)
    else $error("trim set in section C or D");
  a_sect_a_write: assert property (PLL_VEC[0] &&
    $past(HOST_VEC[13:8]) == 6'h3C |=> ($past(HOST_VEC[7:0], 2) & 8'hF3)
    == {SECT_TRIM_EN[0], SECT_PHASE_EN[0], SECT_MUX2[1:0], 2'h0,
    SECT_MUX0[1:0]}) else $error("section A select not applied");
  c_write: cover property (take && HOST_VEC[13]);
  c_read: cover property (take && !HOST_VEC[13]);
  c_bus_rst: cover property (HOST_VEC[15]);
  c_rst_strobe: cover property (HOST_VEC[15] && HOST_VEC[14]);
endmodule : pdcp_properties
bind pdcp_top pdcp_properties u_props (.CORE_CLK, .RESET, .HOST_VEC,
  .PLL_VEC, .SECT_MUX0, .SECT_MUX1, .SECT_MUX2, .SECT_PHASE_EN,
  .SECT_TRIM_EN);

// ==== bench/pdcp_host.sv ====
// Purpose: Bridge-side master of the configuration bus
// Assumes: Drives just after the rising edge
// Notes:   Holds each access request until acknowledge, giving up after 20 clock edges
`timescale 1ns/100ps
module pdcp_host (
  input  wire logic        CORE_CLK,
  input  wire logic [8:0]  PLL_VEC,
  output logic      [16:0] HOST_VEC
);
  logic [15:0] drv_r = 16'h0000;
  assign HOST_VEC = {CORE_CLK, drv_r};
  task automatic access(input logic we, input logic [4:0] adr,
                        input logic [7:0] wd, output logic [8:0] rd);
    int n;
    n = 0;
    @(posedge CORE_CLK) #1;
    drv_r = {2'b01, we, adr, wd};
    do @(posedge CORE_CLK); while (PLL_VEC[0] !== 1'b1 && ++n < 20);
    rd = PLL_VEC;
    #1;
    drv_r = {3'b000, ~adr, ~wd};
  endtask : access
  task automatic bus_reset(input logic [4:0] adr, input logic [7:0] wd);
    @(posedge CORE_CLK) #1;
    drv_r = {3'b111, adr, wd};
    @(posedge CORE_CLK) #1;
    drv_r = {3'b000, ~adr, ~wd};
  endtask : bus_reset
endmodule : pdcp_host

// ==== bench/test_pll_dynamic_config_port.sv ====
// Purpose: Self-checking bench for the configuration port
// Assumes: 25 MHz clock, synchronous reset
// Notes:   Random writes mirrored in a local bank
`timescale 1ns/100ps
module test_pll_dynamic_config_port;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [16:0] hv;
  logic [8:0]  pv, rd;
  logic [7:0]  m0, m1, m2, bank [32] = '{default: 8'h00};
  logic [3:0]  ph, tr;
  int          error_cnt = 0;
  int          checks_done = 0;
  initial forever #20 clk = ~clk;
  pdcp_host u_host (.CORE_CLK(clk), .PLL_VEC(pv), .HOST_VEC(hv));
  pdcp_top u_dut (.CORE_CLK(clk), .RESET(reset), .HOST_VEC(hv),
    .PLL_VEC(pv), .SECT_MUX0(m0), .SECT_MUX1(m1), .SECT_MUX2(m2),
    .SECT_PHASE_EN(ph), .SECT_TRIM_EN(tr));
  task automatic cmp(string what, logic [8:0] exp, logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  function automatic logic [7:0] sect_exp(int s, logic [7:0] r);
    return {r[1:0], s == 0 ? 2'h0 : r[3:2], r[5:4], r[6], s > 1 ? 1'b0 : r[7]};
  endfunction : sect_exp
  task automatic wr(logic [4:0] a, logic [7:0] d);
    u_host.access(1'b1, a, d, rd);
    bank[a] = d;
    cmp("write ack", 9'h001, {8'h00, rd[0]});
  endtask : wr
  task automatic read_all(string name);
    for (int a = 0; a < 32; a++) begin
      u_host.access(1'b0, 5'(a), 8'($urandom), rd);
      cmp("read", {bank[a], 1'b1}, rd);
    end
    $display("Test %s done", name);
  endtask : read_all
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(33594));
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    read_all("reset values");
    for (int i = 0; i < 60; i++) wr(5'($urandom), 8'($urandom));
    wr(5'h1F, 8'hFF);
    wr(5'h00, 8'h00);
    read_all("random writes");
    u_host.bus_reset(5'h1C, ~bank[28]);
    read_all("bus reset keeps bank");
    for (int s = 0; s < 4; s++) begin
      wr(5'h1C + 5'(s), s == 3 ? 8'hFF : 8'($urandom));
      cmp("section", {1'b0, sect_exp(s, bank[28 + s])}, {1'b0, m0[2*s+:2],
        m1[2*s+:2], m2[2*s+:2], ph[s], tr[s]});
    end
    $display("Test sections done");
    wrap_up();
  end
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
endmodule : test_pll_dynamic_config_port
